// File: hw/mscr_regs.sv
// modem status and control registers with their block write buffer
`timescale 1ns/100ps

// parameterised first-in first-out buffer with valid and ready both sides
module mscr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   // pointers carry one extra wrap bit so full and empty differ
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } mscr_fptr_t;

   mscr_fptr_t s_q; // pointer state
   mscr_fptr_t s_d; // next pointer state
   logic [WIDTH-1:0] mem [DEPTH]; // storage words
   logic full; // every slot taken
   logic empty; // no slot taken
   logic push; // word accepted
   logic pop; // word drained

   assign full = (s_q.wr[AW] != s_q.rd[AW]) &&
                 (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
   assign empty = (s_q.wr == s_q.rd);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign push = in_valid_i & ~full;
   assign pop = out_ready_i & ~empty;
   // data comes straight from storage, a flip-flop array
   assign out_data_o = mem[s_q.rd[AW-1:0]];

   // pointer advance; depth must be a power of two, since the wrap bit
   // simply rolls over together with the index
   always_comb begin
      s_d = s_q;
      if (push) begin
         // write slot taken
         s_d.wr = s_q.wr + (AW+1)'(1);
      end
      if (pop) begin
         // head slot released
         s_d.rd = s_q.rd + (AW+1)'(1);
      end
   end

   // pointer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // storage needs no reset, nothing reads an empty slot
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[s_q.wr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// register set facing the host serial port
module mscr_regs (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // serial host port pins, asynchronous to the core clock
   input wire logic HOST_CSN_I,
   input wire logic HOST_SCLK_I,
   input wire logic HOST_CDATA_I,
   output logic HOST_RDATA_O,
   output logic HOST_RDATA_OE_O,
   // neighbouring registers and mode, same clock
   input wire logic [15:0] IRQ_MASK_I,
   input wire logic POWERSAVE_I,
   input wire logic TX_MODE_I,
   // datapath events, same clock
   input wire mscr_pkg::mscr_evt_t EVT_I,
   // interrupt and validity
   output logic IRQ_N_O,
   output logic STATUS_VALID_O,
   // configuration towards the datapaths
   output mscr_pkg::mscr_tone_t TONE_O,
   output mscr_pkg::mscr_ctrl_t CTRL_O,
   output mscr_pkg::mscr_mode_t MODE_O,
   output logic TX_STOP_OK_O,
   // program block words towards the block engine
   output logic [15:0] BLK_DATA_O,
   output logic BLK_VALID_O,
   input wire logic BLK_READY_I
);
   // whole register state of the block
   typedef struct packed {
      logic [2:0] sync1; // first synchroniser stage
      logic [2:0] sync2; // second synchroniser stage
      logic sclk_prev; // last settled serial clock
      logic [4:0] cnt; // bits taken in this frame
      logic [22:0] sh; // incoming shift register
      logic reading; // frame is a flags read
      logic [15:0] out_sh; // outgoing read word
      logic rdata; // serial reply bit
      mscr_pkg::mscr_tone_t tone; // tone select word
      mscr_pkg::mscr_ctrl_t ctrl; // framing control word
      logic [15:0] flags; // sticky event flags
      logic free; // block port may take a word
      logic push; // block word handed to buffer
      logic [15:0] wr_data; // block word held for buffer
   } mscr_state_t;

   mscr_state_t s_q; // registered state
   mscr_state_t s_d; // next state
   logic fifo_ready; // buffer has room
   logic csn; // settled chip select, low active
   logic sclk; // settled serial clock
   logic din; // settled serial data
   logic rise; // serial clock rising edge
   logic fall; // serial clock falling edge
   logic [23:0] word; // complete frame with newest bit
   logic read_clr; // flags read this cycle
   logic [2:0] fmt; // current message format
   logic unsized; // formats without a size field
   logic sized; // formats carrying crc
   logic rate_ok; // rate bits may be set
   logic [15:0] set; // flags set this cycle
   logic [15:0] view; // flags as the host sees them

   assign csn = s_q.sync2[2];
   assign sclk = s_q.sync2[1];
   assign din = s_q.sync2[0];
   assign rise = sclk & ~s_q.sclk_prev;
   assign fall = ~sclk & s_q.sclk_prev;
   // newest bit joins the shift register to give the whole frame
   assign word = {s_q.sh, din};
   assign fmt = s_q.ctrl.fmt;
   assign unsized = (fmt == mscr_pkg::FMT_RAW) ||
                    (fmt == mscr_pkg::FMT_UNSIZED) ||
                    (fmt == mscr_pkg::FMT_UNSIZED_FEC);
   assign sized = (fmt == mscr_pkg::FMT_SIZED) ||
                  (fmt == mscr_pkg::FMT_SIZED_IL);

   // host view: free flag in bit 0, nothing while held in powersave
   // the free flag is live, not stored, so a read cannot clear it
   always_comb begin
      view = s_q.flags;
      view[mscr_pkg::FLG_FREE] = s_q.free;
      if (POWERSAVE_I) begin
         view = '0;
      end
   end

   // rate bits qualify only in receive: on sync in raw format, on a good head otherwise
   assign rate_ok = ~TX_MODE_I &
      ((fmt == mscr_pkg::FMT_RAW) ? EVT_I.frame_sync : EVT_I.head_ok);

   // events that set flags this cycle
   always_comb begin
      set = '0;
      set[mscr_pkg::FLG_DTMF] = EVT_I.dtmf;
      set[mscr_pkg::FLG_AUX2] = EVT_I.aux_conv_two;
      set[mscr_pkg::FLG_AUX1] = EVT_I.aux_conv_one;
      if (TX_MODE_I) begin
         // unsized formats end only once the last word was flagged
         set[mscr_pkg::FLG_END] = EVT_I.tx_last_bit &
            (~unsized | s_q.ctrl.last_tx);
         set[mscr_pkg::FLG_RDY] = EVT_I.tx_need;
      end else begin
         set[mscr_pkg::FLG_END] = EVT_I.rx_last;
         set[mscr_pkg::FLG_RDY] = EVT_I.rx_data | EVT_I.rx_last;
         set[mscr_pkg::FLG_CRC] = EVT_I.rx_last & EVT_I.crc_bad &
            sized;
      end
      set[mscr_pkg::FLG_R2400] = rate_ok & EVT_I.rate_2400;
      set[mscr_pkg::FLG_R1200] = rate_ok & ~EVT_I.rate_2400;
   end

   // serial port, flag update and block port handling
   always_comb begin
      s_d = s_q;
      read_clr = 1'b0;
      s_d.push = 1'b0;
      // pins pass two flip-flops before any logic reads them
      s_d.sync1 = {HOST_CSN_I, HOST_SCLK_I, HOST_CDATA_I};
      s_d.sync2 = s_q.sync1;
      // edge history is taken from the settled clock only
      s_d.sclk_prev = sclk;
      if (csn) begin
         // deselected: frame aborts, reply pin released
         s_d.cnt = '0;
         s_d.reading = 1'b0;
         s_d.rdata = 1'b0;
      end else if (rise) begin
         s_d.sh = word[22:0];
         s_d.cnt = s_q.cnt + 5'h01;
         if (s_q.cnt == mscr_pkg::ADDR_LAST_BIT &&
             word[7:0] == mscr_pkg::ADDR_FLAGS) begin
            // snapshot taken as the address completes
            s_d.reading = 1'b1;
            s_d.out_sh = view;
            read_clr = 1'b1;
         end
         if (s_q.cnt == mscr_pkg::FRAME_LAST_BIT && !s_q.reading) begin
            case (word[23:16])
               mscr_pkg::ADDR_TONE: begin
                  s_d.tone = word[15:0];
                  s_d.tone.rsv = '0;
               end
               mscr_pkg::ADDR_CTRL: begin
                  s_d.ctrl = word[15:0];
                  s_d.ctrl.rsv_hi = '0;
                  s_d.ctrl.rsv_lo = '0;
               end
               mscr_pkg::ADDR_BLOCK: begin
                  s_d.push = 1'b1;
                  s_d.wr_data = word[15:0];
               end
               default: begin
                  // other addresses belong to other blocks
               end
            endcase
         end
      end else if (fall && s_q.reading) begin
         // reply changes on the falling edge, host samples on the rise
         s_d.rdata = s_q.out_sh[15];
         s_d.out_sh = {s_q.out_sh[14:0], 1'b0};
      end
      // free drops on a block write and returns once the buffer has room
      s_d.free = ~s_d.push & ~s_q.push & fifo_ready;
      // a set in the clearing cycle wins over the read clear
      s_d.flags = (read_clr ? (s_q.flags & mscr_pkg::READ_KEEP) :
                   s_q.flags) | set;
      s_d.flags[1:0] = 2'h0;
      // summary bit for any masked flag change, free rising included
      if ((|(set[14:0] & IRQ_MASK_I[14:0])) ||
          (s_d.free & ~s_q.free & IRQ_MASK_I[mscr_pkg::FLG_FREE])) begin
         s_d.flags[mscr_pkg::FLG_IRQ] = 1'b1;
      end
      if (POWERSAVE_I) begin
         s_d.flags = mscr_pkg::FLAGS_RST;
      end
   end

   // state registers
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         s_q <= '0;
         // synchronisers idle deselected with the clock low, so the
         // edge detector sees no false edge as reset ends
         s_q.sync1 <= 3'h4;
         s_q.sync2 <= 3'h4;
         s_q.tone <= mscr_pkg::TONE_RST;
         s_q.ctrl <= mscr_pkg::CTRL_RST;
         s_q.flags <= mscr_pkg::FLAGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // block words queue here; the host paces itself on the free flag
   mscr_fifo #(
      .WIDTH(mscr_pkg::BLK_WIDTH),
      .DEPTH(mscr_pkg::BLK_DEPTH)
   ) u_blk_fifo (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .in_data_i(s_q.wr_data),
      .in_valid_i(s_q.push),
      .in_ready_o(fifo_ready),
      .out_data_o(BLK_DATA_O),
      .out_valid_o(BLK_VALID_O),
      .out_ready_i(BLK_READY_I)
   );

   // decoded modem behaviour
   always_comb begin
      MODE_O = '0;
      // raw: sync search and 16 bit words in rx, host framed words in tx
      MODE_O.raw_words = s_q.ctrl.raw;
      // formatted: sync patterns then a head from the low control byte
      MODE_O.send_sync_head = ~s_q.ctrl.raw;
      MODE_O.interleave_head = s_q.ctrl.interleave;
      MODE_O.fec = (fmt == mscr_pkg::FMT_UNSIZED_FEC) | sized;
      MODE_O.sized_crc = sized;
      MODE_O.payload_il = (fmt == mscr_pkg::FMT_SIZED_IL);
      // reserved codes six and seven are reported unusable
      MODE_O.fmt_valid = (fmt <= mscr_pkg::FMT_SIZED_IL);
      MODE_O.seed = s_q.ctrl.scr;
      // user bit rides in the head untouched by format or coding
      MODE_O.user_flag = s_q.ctrl.user;
      MODE_O.head_ctrl = s_q.ctrl[7:0];
   end

   // modulation may stop in unsized tx once the last word is flagged
   // timing of the last word flag is left to the host
   assign TX_STOP_OK_O = TX_MODE_I & unsized & s_q.ctrl.last_tx;
   // interrupt pin is low while summary bit and global mask are both set
   assign IRQ_N_O = ~(s_q.flags[mscr_pkg::FLG_IRQ] &
                      IRQ_MASK_I[mscr_pkg::MASK_GLOBAL]);
   assign STATUS_VALID_O = ~POWERSAVE_I;
   assign HOST_RDATA_O = s_q.rdata;
   assign HOST_RDATA_OE_O = s_q.reading;
   assign TONE_O = s_q.tone;
   assign CTRL_O = s_q.ctrl;
endmodule

// File: common/mscr_pkg.sv
// shared constants and carrier types of the modem status and control registers
package mscr_pkg;
   // register addresses on the serial host port
   localparam logic [7:0] ADDR_TONE = 8'hC3;
   localparam logic [7:0] ADDR_FLAGS = 8'hC6;
   localparam logic [7:0] ADDR_CTRL = 8'hC7;
   localparam logic [7:0] ADDR_BLOCK = 8'hC8;
   // serial frame layout: 8 address bits then 16 data bits
   localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
   // event flag positions
   localparam int FLG_IRQ = 15;
   localparam int FLG_DTMF = 12;
   localparam int FLG_AUX2 = 9;
   localparam int FLG_AUX1 = 8;
   localparam int FLG_END = 7;
   localparam int FLG_RDY = 6;
   localparam int FLG_CRC = 5;
   localparam int FLG_R2400 = 4;
   localparam int FLG_R1200 = 3;
   localparam int FLG_FREE = 0;
   localparam int MASK_GLOBAL = 15;
   // a read keeps only these bits, bits 15 to 2 clear
   localparam logic [15:0] READ_KEEP = 16'h0003;
   // reset values
   localparam logic [15:0] TONE_RST = 16'h0000;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   // message format codes
   localparam logic [2:0] FMT_RAW = 3'h0;
   localparam logic [2:0] FMT_HEAD = 3'h1;
   localparam logic [2:0] FMT_UNSIZED = 3'h2;
   localparam logic [2:0] FMT_UNSIZED_FEC = 3'h3;
   localparam logic [2:0] FMT_SIZED = 3'h4;
   localparam logic [2:0] FMT_SIZED_IL = 3'h5;
   // scrambler seed codes
   localparam logic [1:0] SCR_STD = 2'h0;
   localparam logic [1:0] SCR_SEED1 = 2'h1;
   localparam logic [1:0] SCR_SEED2 = 2'h2;
   localparam logic [1:0] SCR_NONE = 2'h3;
   // block write buffer
   localparam int BLK_WIDTH = 16;
   localparam int BLK_DEPTH = 8;

   // transmit tone word
   typedef struct packed {
      logic [9:0] rsv;
      logic twist;
      logic single;
      logic [3:0] code;
   } mscr_tone_t;

   // link framing control word
   typedef struct packed {
      logic [2:0] sync_sel;
      logic [1:0] rsv_hi;
      logic raw;
      logic last_tx;
      logic interleave;
      logic [2:0] fmt;
      logic [1:0] rsv_lo;
      logic user;
      logic [1:0] scr;
   } mscr_ctrl_t;

   // one-cycle events from the tone, aux and modem datapaths
   typedef struct packed {
      logic dtmf;
      logic aux_conv_two;
      logic aux_conv_one;
      logic rx_last;
      logic rx_data;
      logic crc_bad;
      logic frame_sync;
      logic head_ok;
      logic rate_2400;
      logic tx_last_bit;
      logic tx_need;
   } mscr_evt_t;

   // decoded modem behaviour for the datapath
   typedef struct packed {
      logic raw_words;
      logic send_sync_head;
      logic interleave_head;
      logic fec;
      logic sized_crc;
      logic payload_il;
      logic fmt_valid;
      logic [1:0] seed;
      logic user_flag;
      logic [7:0] head_ctrl;
   } mscr_mode_t;
endpackage

// File: testbench/mscr_regs_sva.sv
// assertion checker for the modem status and control registers
`timescale 1ns/100ps
module mscr_regs_chk (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // watched ports
   input wire logic HOST_CSN_I,
   input wire logic HOST_RDATA_OE_O,
   input wire logic [15:0] IRQ_MASK_I,
   input wire logic POWERSAVE_I,
   input wire logic TX_MODE_I,
   input wire mscr_pkg::mscr_evt_t EVT_I,
   input wire logic IRQ_N_O,
   input wire logic STATUS_VALID_O,
   input wire mscr_pkg::mscr_tone_t TONE_O,
   input wire mscr_pkg::mscr_ctrl_t CTRL_O,
   input wire mscr_pkg::mscr_mode_t MODE_O,
   input wire logic TX_STOP_OK_O,
   input wire logic [15:0] BLK_DATA_O,
   input wire logic BLK_VALID_O,
   input wire logic BLK_READY_I
);
   // one domain, checks idle during reset
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // masked dtmf event drives the pin low on the flag cycle
   property p_irq_set;
      EVT_I.dtmf && IRQ_MASK_I[12] && IRQ_MASK_I[15] && !POWERSAVE_I
      ##1 IRQ_MASK_I[15] && !POWERSAVE_I |-> !IRQ_N_O;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq late");
   // global mask off keeps the pin quiet
   property p_irq_mask;
      !IRQ_MASK_I[15] |-> IRQ_N_O;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq leak");
   // held powersave wipes any pending summary
   property p_ps_irq;
      POWERSAVE_I ##1 POWERSAVE_I |-> IRQ_N_O;
   endproperty
   a_ps_irq: assert property (p_ps_irq) else $error("ps irq");
   property p_valid;
      STATUS_VALID_O == !POWERSAVE_I;
   endproperty
   a_valid: assert property (p_valid) else $error("valid bad");
   // stop permission only for the unsized formats in transmit
   property p_stop;
      TX_STOP_OK_O == (TX_MODE_I && CTRL_O.last_tx &&
         CTRL_O.fmt inside {3'h0, 3'h2, 3'h3});
   endproperty
   a_stop: assert property (p_stop) else $error("stop bad");
   property p_fmt;
      MODE_O.fec == (CTRL_O.fmt inside {3'h3, 3'h4, 3'h5}) &&
      MODE_O.payload_il == (CTRL_O.fmt == 3'h5) &&
      MODE_O.fmt_valid == (CTRL_O.fmt <= 3'h5);
   endproperty
   a_fmt: assert property (p_fmt) else $error("fmt decode");
   property p_raw;
      MODE_O.raw_words == CTRL_O.raw && MODE_O.send_sync_head == !CTRL_O.raw;
   endproperty
   a_raw: assert property (p_raw) else $error("raw decode");
   property p_il;
      MODE_O.interleave_head == CTRL_O.interleave;
   endproperty
   a_il: assert property (p_il) else $error("interleave");
   property p_seed;
      MODE_O.seed == CTRL_O.scr && MODE_O.user_flag == CTRL_O.user &&
      MODE_O.head_ctrl == CTRL_O[7:0];
   endproperty
   a_seed: assert property (p_seed) else $error("seed user");
   // reserved fields always read back zero
   property p_rsv;
      TONE_O.rsv == 10'h000 && CTRL_O.rsv_hi == 2'h0 && CTRL_O.rsv_lo == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   // a stalled head word must not move
   property p_hold;
      BLK_VALID_O && !BLK_READY_I |=> BLK_VALID_O && $stable(BLK_DATA_O);
   endproperty
   a_hold: assert property (p_hold) else $error("fifo head");
   // reply driver lets go soon after deselect
   property p_oe;
      $rose(HOST_CSN_I) |-> ##[1:8] !HOST_RDATA_OE_O;
   endproperty
   a_oe: assert property (p_oe) else $error("oe stuck");
endmodule

bind mscr_regs mscr_regs_chk u_chk (.CORE_CLK_I(CORE_CLK_I),
   .RST_I(RST_I), .HOST_CSN_I(HOST_CSN_I),
   .HOST_RDATA_OE_O(HOST_RDATA_OE_O), .IRQ_MASK_I(IRQ_MASK_I),
   .POWERSAVE_I(POWERSAVE_I), .TX_MODE_I(TX_MODE_I), .EVT_I(EVT_I),
   .IRQ_N_O(IRQ_N_O), .STATUS_VALID_O(STATUS_VALID_O), .TONE_O(TONE_O),
   .CTRL_O(CTRL_O), .MODE_O(MODE_O), .TX_STOP_OK_O(TX_STOP_OK_O),
   .BLK_DATA_O(BLK_DATA_O), .BLK_VALID_O(BLK_VALID_O),
   .BLK_READY_I(BLK_READY_I));

// File: testbench/mscr_host.sv
// host side serial port model
`timescale 1ns/100ps
module mscr_host #(
   parameter int HP = 20
) (
   // core clock used only for pacing
   input wire logic clk_i,
   // serial pins
   output logic csn_o,
   output logic sclk_o,
   output logic cdata_o,
   input wire logic rdata_i,
   input wire logic rdata_oe_i
);
   // deselected, clock parked low
   initial begin
      csn_o = 1'b1;
      sclk_o = 1'b0;
      cdata_o = 1'b0;
   end
   // half bit time, slow so the pin synchronisers keep up
   task hw();
      repeat (HP) @(posedge clk_i);
      #1;
   endtask
   // one frame: address then data, msb first, reply sampled at rises
   task xfer(input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
      logic [23:0] w;
      w = {a, d};
      q = 'x;
      hw();
      csn_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         cdata_o = w[i];
         hw();
         // an undriven reply line counts as unknown
         if (i < 16) q[i] = rdata_oe_i ? rdata_i : 1'bx;
         sclk_o = 1'b1;
         hw();
         sclk_o = 1'b0;
      end
      hw();
      csn_o = 1'b1;
      // stale data bit is flipped so it never looks meaningful
      cdata_o = ~cdata_o;
      hw();
   endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the modem status and control registers
`timescale 1ns/100ps
module tb_top;
   // stimulus and observed signals
   logic clk, rst, csn, sclk, cdata, rdata, rdata_oe, ps, tx;
   logic irq_n, st_valid, stop_ok, blk_valid, blk_ready;
   logic [15:0] mask, blk_data, q;
   mscr_pkg::mscr_evt_t evt;
   mscr_pkg::mscr_tone_t tone;
   mscr_pkg::mscr_ctrl_t ctrl;
   mscr_pkg::mscr_mode_t mode;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   // host model and design
   mscr_host h (.clk_i(clk), .csn_o(csn), .sclk_o(sclk), .cdata_o(cdata),
      .rdata_i(rdata), .rdata_oe_i(rdata_oe));
   mscr_regs dut (.CORE_CLK_I(clk), .RST_I(rst), .HOST_CSN_I(csn),
      .HOST_SCLK_I(sclk), .HOST_CDATA_I(cdata), .HOST_RDATA_O(rdata),
      .HOST_RDATA_OE_O(rdata_oe), .IRQ_MASK_I(mask), .POWERSAVE_I(ps),
      .TX_MODE_I(tx), .EVT_I(evt), .IRQ_N_O(irq_n),
      .STATUS_VALID_O(st_valid), .TONE_O(tone), .CTRL_O(ctrl),
      .MODE_O(mode), .TX_STOP_OK_O(stop_ok), .BLK_DATA_O(blk_data),
      .BLK_VALID_O(blk_valid), .BLK_READY_I(blk_ready));
   // 200 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // verdict and end of run
   task end_sim();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, about half again the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 75000) begin
         n_errors++;
         end_sim();
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      h.xfer(a, d, q);
   endtask
   // read of the flags, which also clears them
   task rd(input logic [15:0] e);
      h.xfer(mscr_pkg::ADDR_FLAGS, 16'h0000, q);
      chk(q, e);
   endtask
   // one-cycle datapath event
   task pulse(input logic [10:0] e);
      @(posedge clk);
      #1 evt = e;
      @(posedge clk);
      #1 evt = '0;
   endtask
   // set control word and mode, fire an event, read the flags
   task ev(input logic [15:0] c, input logic t, input logic [10:0] e,
      input logic [15:0] x);
      wr(mscr_pkg::ADDR_CTRL, c);
      tx = t;
      pulse(e);
      rd(x);
   endtask
   initial begin
      logic [15:0] c;
      rst = 1'b1;
      mask = '0;
      ps = 1'b0;
      tx = 1'b0;
      evt = '0;
      blk_ready = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      rd(16'h0001);
      wr(mscr_pkg::ADDR_TONE, 16'h0035);
      chk(tone, 16'h0035);
      wr(8'hC4, 16'h0012);
      chk(tone, 16'h0035);
      // every format and seed code, reserved formats too
      for (int i = 0; i < 8; i++) begin
         c = {5'h00, i == 0, 1'b0, i[0], i[2:0], 2'h0, i[1], i[1:0]};
         wr(mscr_pkg::ADDR_CTRL, c);
         chk(ctrl, c);
         chk({15'h0, mode.fmt_valid}, {15'h0, i < 6});
         chk({15'h0, mode.sized_crc}, {15'h0, i == 4 || i == 5});
      end
      // masked dtmf raises, read clears
      mask = 16'h9000;
      pulse(11'h400);
      @(posedge clk);
      #1 chk({15'h0, irq_n}, 16'h0000);
      rd(16'h9001);
      chk({15'h0, irq_n}, 16'h0001);
      mask = 16'h0000;
      ev(16'h0000, 1'b0, 11'h200, 16'h0201);
      ev(16'h0000, 1'b0, 11'h100, 16'h0101);
      ev(16'h0080, 1'b0, 11'h0A0, 16'h00E1);
      ev(16'h0080, 1'b0, 11'h040, 16'h0041);
      ev(16'h0000, 1'b0, 11'h014, 16'h0011);
      ev(16'h0080, 1'b0, 11'h014, 16'h0001);
      ev(16'h0080, 1'b0, 11'h008, 16'h0009);
      ev(16'h0080, 1'b1, 11'h002, 16'h0081);
      ev(16'h0040, 1'b1, 11'h002, 16'h0001);
      ev(16'h0240, 1'b1, 11'h002, 16'h0081);
      chk({15'h0, stop_ok}, 16'h0001);
      ev(16'h0080, 1'b1, 11'h001, 16'h0041);
      rd(16'h0001);
      tx = 1'b0;
      // powersave hides the flags and the interrupt
      mask = 16'h9000;
      ps = 1'b1;
      @(posedge clk);
      #1 chk({15'h0, st_valid}, 16'h0000);
      pulse(11'h400);
      @(posedge clk);
      #1 chk({15'h0, irq_n}, 16'h0001);
      rd(16'h0000);
      ps = 1'b0;
      mask = 16'h0000;
      // fill the block buffer with the drain stalled
      for (int i = 0; i < 8; i++) begin
         wr(mscr_pkg::ADDR_BLOCK, {4'h1, 8'h00, i[3:0]});
      end
      rd(16'h0000);
      blk_ready = 1'b1;
      for (int i = 0; i < 8; i++) begin
         chk(blk_data, {4'h1, 8'h00, i[3:0]});
         @(posedge clk);
         #1;
      end
      chk({15'h0, blk_valid}, 16'h0000);
      rd(16'h0001);
      // second reset mid-run brings back the reset values
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk(tone, mscr_pkg::TONE_RST);
      chk(ctrl, mscr_pkg::CTRL_RST);
      chk({15'h0, irq_n}, 16'h0001);
      repeat (6) @(posedge clk);
      #1;
      rd(16'h0001);
      end_sim();
   end
endmodule
